// ==== bdmd_banked_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - status bits 6:5 choose bank 0..3
// - bank above 7-bit offset, 128 bytes each
// - low offsets special, rest general RAM
// - every bank has special register region
// - status and pointer mirrored in all banks
// - direct via bank field, indirect via pointer
module bdmd_banked_mem #(
    parameter int GP_DEPTH = 512
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        CLK_EN,
    // core access
    input  wire logic        ACC_EN,
    input  wire logic        ACC_WR,
    input  wire logic [6:0]  ACC_OFS,
    input  wire logic [7:0]  ACC_WDATA,
    output logic      [7:0]  ACC_RDATA,
    output logic             ACC_RVALID,
    // special register port toward peripherals
    output logic             SFR_EN,
    output logic             SFR_WR,
    output logic      [8:0]  SFR_ADDR,
    output logic      [7:0]  SFR_WDATA,
    input  wire logic [7:0]  SFR_RDATA,
    // register views
    output logic      [7:0]  STATUS_OUT,
    output logic      [7:0]  POINTER_OUT
);
    import bdmd_pkg::*;

    // the 9-bit ram index must always land inside the array
    if (GP_DEPTH < 512) begin : g_depth_check
        $error("GP_DEPTH too small for banked map");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] status_reg,  status_next;   // core flags and bank
    logic [7:0] ptr_reg,     ptr_next;      // indirect pointer
    logic [7:0] rdata_reg,   rdata_next;    // read answer
    logic       rvalid_reg,  rvalid_next;
    logic       sfr_en_reg,  sfr_en_next;
    logic       sfr_wr_reg,  sfr_wr_next;
    logic [8:0] sfr_addr_reg, sfr_addr_next;
    logic [7:0] sfr_wd_reg,  sfr_wd_next;
    logic [7:0] gp_mem [GP_DEPTH];          // general purpose RAM
    logic       gp_we;
    logic [8:0] gp_wa;
    logic       pend_reg,    pend_next;     // special read awaiting data

    // ----------------------------------------------------------------
    // address forming
    // ----------------------------------------------------------------
    logic [1:0] bank;        // selected bank
    logic [8:0] direct_addr; // direct full address
    logic [8:0] eff_addr;    // after indirect redirect
    logic       indirect;    // offset zero used
    bdmd_dec_if dif ();

    // bank and redirect selection
    always_comb begin
        bank        = {status_reg[BDMD_BANK_HI_POS], status_reg[BDMD_BANK_LO_POS]};
        direct_addr = {bank, ACC_OFS};
        indirect    = (ACC_OFS == BDMD_OFS_INDIR);
        // indirect uses pointer plus high bank bit
        eff_addr    = indirect ? {status_reg[BDMD_BANK_HI_POS], ptr_reg} : direct_addr;
        dif.addr    = eff_addr;
    end

    bdmd_addr_decode u_dec (
        .d (dif.dec)
    );

    // ----------------------------------------------------------------
    // access handling
    // ----------------------------------------------------------------
    always_comb begin
        status_next   = status_reg;
        ptr_next      = ptr_reg;
        rdata_next    = rdata_reg;
        rvalid_next   = 1'b0;
        sfr_en_next   = 1'b0;
        sfr_wr_next   = 1'b0;
        sfr_addr_next = sfr_addr_reg;
        sfr_wd_next   = sfr_wd_reg;
        pend_next     = 1'b0;
        gp_we         = 1'b0;
        gp_wa         = dif.gp_index;
        // deliver pending special register data
        if (pend_reg) begin
            rdata_next  = SFR_RDATA;
            rvalid_next = 1'b1;
        end
        if (ACC_EN) begin
            unique case (bdmd_target_e'(dif.target))
                // self-indirect: reads zero, writes dropped
                BDMD_T_INDIR: begin
                    if (!ACC_WR) begin
                        rdata_next  = BDMD_ZERO;
                        rvalid_next = 1'b1;
                    end
                end
                BDMD_T_STATUS: begin
                    if (ACC_WR) begin
                        status_next = ACC_WDATA;
                    end else begin
                        rdata_next  = status_reg;
                        rvalid_next = 1'b1;
                    end
                end
                BDMD_T_PTR: begin
                    if (ACC_WR) begin
                        ptr_next = ACC_WDATA;
                    end else begin
                        rdata_next  = ptr_reg;
                        rvalid_next = 1'b1;
                    end
                end
                // other special registers go out to peripherals
                BDMD_T_SFR: begin
                    sfr_en_next   = 1'b1;
                    sfr_wr_next   = ACC_WR;
                    sfr_addr_next = eff_addr;
                    sfr_wd_next   = ACC_WDATA;
                    pend_next     = !ACC_WR;
                end
                BDMD_T_GPR: begin
                    if (ACC_WR) begin
                        gp_we = 1'b1;
                    end else begin
                        rdata_next  = gp_mem[dif.gp_index];
                        rvalid_next = 1'b1;
                    end
                end
                default: begin
                    rvalid_next = 1'b0;
                end
            endcase
        end
    end

    // register update
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            status_reg   <= BDMD_STATUS_RST;
            ptr_reg      <= BDMD_PTR_RST;
            rdata_reg    <= BDMD_ZERO;
            rvalid_reg   <= 1'b0;
            sfr_en_reg   <= 1'b0;
            sfr_wr_reg   <= 1'b0;
            sfr_addr_reg <= '0;
            sfr_wd_reg   <= BDMD_ZERO;
            pend_reg     <= 1'b0;
        end else if (CLK_EN) begin
            status_reg   <= status_next;
            ptr_reg      <= ptr_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= rvalid_next;
            sfr_en_reg   <= sfr_en_next;
            sfr_wr_reg   <= sfr_wr_next;
            sfr_addr_reg <= sfr_addr_next;
            sfr_wd_reg   <= sfr_wd_next;
            pend_reg     <= pend_next;
        end
    end

    // ram write, no reset on storage
    always_ff @(posedge REF_CLK) begin
        if (CLK_EN && gp_we) begin
            gp_mem[gp_wa] <= ACC_WDATA;
        end
    end

    assign ACC_RDATA   = rdata_reg;
    assign ACC_RVALID  = rvalid_reg;
    assign SFR_EN      = sfr_en_reg;
    assign SFR_WR      = sfr_wr_reg;
    assign SFR_ADDR    = sfr_addr_reg;
    assign SFR_WDATA   = sfr_wd_reg;
    assign STATUS_OUT  = status_reg;
    assign POINTER_OUT = ptr_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    bank_select_a: assert property (ACC_EN && CLK_EN && ACC_OFS != 7'h00 && dif.target == 3'(BDMD_T_SFR)
        |=> SFR_ADDR[8:7] == $past(status_reg[6:5])) else $error("bank select wrong");
    status_mirror_a: assert property (CLK_EN && ACC_EN && ACC_WR && ACC_OFS == BDMD_OFS_STATUS
        |=> STATUS_OUT == $past(ACC_WDATA)) else $error("status write lost");
    pointer_write_a: assert property (CLK_EN && ACC_EN && ACC_WR && ACC_OFS == BDMD_OFS_PTR
        |=> POINTER_OUT == $past(ACC_WDATA)) else $error("pointer write lost");
    self_zero_a: assert property (CLK_EN && ACC_EN && !ACC_WR && ACC_OFS == 7'h00 && ptr_reg[6:0] == 7'h00
        |=> ACC_RVALID && ACC_RDATA == 8'h00) else $error("self indirect not zero");
    sfr_low_a: assert property (SFR_EN |-> SFR_ADDR[6:0] < 7'h20) else $error("special decode high");
    gp_read_a: assert property (CLK_EN && ACC_EN && !ACC_WR && ACC_OFS >= 7'h20
        |=> ACC_RVALID) else $error("ram read no answer");
    indirect_sfr_a: assert property (CLK_EN && ACC_EN && ACC_OFS == 7'h00 && dif.target == 3'(BDMD_T_SFR)
        |=> SFR_ADDR[7:0] == $past(ptr_reg)) else $error("indirect addr wrong");
    sfr_read_a: assert property (CLK_EN && ACC_EN && !ACC_WR && dif.target == 3'(BDMD_T_SFR)
        ##1 CLK_EN |=> ACC_RVALID) else $error("special read no answer");
    cov_indirect: cover property (ACC_EN && ACC_OFS == 7'h00);
    cov_bank3: cover property (ACC_EN && status_reg[6:5] == 2'b11);
    cov_sfr_read: cover property (SFR_EN && !SFR_WR);
endmodule
`default_nettype wire

// ==== bdmd_pkg.sv ====
package bdmd_pkg;
    // ----------------------------------------------------------------
    // address layout
    // ----------------------------------------------------------------
    localparam int          BDMD_OFS_W       = 7;
    localparam int          BDMD_ADDR_W      = 9;
    localparam int          BDMD_BANKS       = 4;
    localparam logic [6:0]  BDMD_OFS_LAST    = 7'h7F;
    localparam logic [6:0]  BDMD_OFS_INDIR   = 7'h00;
    localparam logic [6:0]  BDMD_OFS_STATUS  = 7'h03;
    localparam logic [6:0]  BDMD_OFS_PTR     = 7'h04;
    localparam logic [6:0]  BDMD_OFS_GP_B0   = 7'h20;
    localparam logic [6:0]  BDMD_OFS_GP_BN   = 7'h20;
    localparam logic [6:0]  BDMD_OFS_SHARED  = 7'h70;
    localparam int          BDMD_BANK_HI_POS = 6;
    localparam int          BDMD_BANK_LO_POS = 5;
    localparam logic [7:0]  BDMD_STATUS_RST  = 8'h00;
    localparam logic [7:0]  BDMD_PTR_RST     = 8'h00;
    localparam logic [7:0]  BDMD_ZERO        = 8'h00;
    localparam logic [8:0]  BDMD_GP_BYTES    = 9'h170;
    // ----------------------------------------------------------------
    // decode classes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BDMD_T_INDIR,
        BDMD_T_STATUS,
        BDMD_T_PTR,
        BDMD_T_SFR,
        BDMD_T_GPR
    } bdmd_target_e;
endpackage

// ==== bdmd_dec_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// carries an address to the decoder and its answer back
interface bdmd_dec_if;
    logic [8:0]   addr;
    logic [2:0]   target;
    logic [8:0]   gp_index;
    modport dec (input addr, output target, output gp_index);
    modport use_side (output addr, input target, input gp_index);
endinterface
`default_nettype wire

// ==== bdmd_addr_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module bdmd_addr_decode (
    // decode port
    bdmd_dec_if.dec d
);
    import bdmd_pkg::*;
    // ----------------------------------------------------------------
    // classify a full 9-bit address
    // ----------------------------------------------------------------
    logic [6:0] ofs;    // offset within bank
    logic [1:0] bank;   // bank number
    // combinational classification
    always_comb begin
        ofs        = d.addr[6:0];
        bank       = d.addr[8:7];
        d.gp_index = '0;
        if (ofs == BDMD_OFS_INDIR) begin
            d.target = 3'(BDMD_T_INDIR);
        end else if (ofs == BDMD_OFS_STATUS) begin
            d.target = 3'(BDMD_T_STATUS);
        end else if (ofs == BDMD_OFS_PTR) begin
            d.target = 3'(BDMD_T_PTR);
        end else if (ofs < ((bank == 2'd0) ? BDMD_OFS_GP_B0 : BDMD_OFS_GP_BN)) begin
            d.target = 3'(BDMD_T_SFR);
        end else begin
            d.target = 3'(BDMD_T_GPR);
            // top 16 bytes of every bank share bank 0 storage
            if (ofs >= BDMD_OFS_SHARED) begin
                d.gp_index = {2'b00, ofs};
            end else begin
                d.gp_index = {bank, ofs};
            end
        end
    end
endmodule
`default_nettype wire

// ==== bdmd_periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// peripheral side of the special register port
module bdmd_periph_model (
    // clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       RSTN,
    // special register port
    input  wire logic       SFR_EN,
    input  wire logic       SFR_WR,
    input  wire logic [8:0] SFR_ADDR,
    output logic      [7:0] SFR_RDATA
);
    logic [7:0] last_reg;  // last answer given
    logic       held_reg;  // answer still held this cycle
    logic [7:0] sig;       // address signature
    assign sig = SFR_ADDR[7:0] ^ 8'hA5;
    // answer in the strobe cycle and the one after, then scramble
    assign SFR_RDATA = (SFR_EN && !SFR_WR) ? sig : (held_reg ? last_reg : ~last_reg);
    // ----------------------------------------------------------------
    // answer bookkeeping
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            last_reg <= 8'h00;
            held_reg <= 1'b0;
        end else if (SFR_EN && !SFR_WR) begin
            last_reg <= sig;
            held_reg <= 1'b1;
        end else begin
            // stale data must not look valid
            held_reg <= 1'b0;
            if (!held_reg) begin
                last_reg <= ~last_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== banked_data_memory_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_decoder_test;
    logic       ref_clk = 0, rstn = 0, acc_en = 0, acc_wr = 0;
    logic [6:0] acc_ofs = 7'h00;
    logic [7:0] acc_wdata = 8'h00, acc_rdata, sfr_wdata, sfr_rdata, status_out, pointer_out;
    logic       acc_rvalid, sfr_en, sfr_wr;
    logic [8:0] sfr_addr, last_addr;
    logic       clk_en = 1'b1, last_wr;
    logic [7:0] last_wd;
    int         n_fail = 0, check_count = 0;
    logic [7:0] rd;
    always #5 ref_clk = ~ref_clk;
    bdmd_banked_mem #(.GP_DEPTH(512)) dut (.REF_CLK(ref_clk), .RSTN(rstn), .CLK_EN(clk_en),
        .ACC_EN(acc_en), .ACC_WR(acc_wr), .ACC_OFS(acc_ofs), .ACC_WDATA(acc_wdata),
        .ACC_RDATA(acc_rdata), .ACC_RVALID(acc_rvalid), .SFR_EN(sfr_en), .SFR_WR(sfr_wr),
        .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
        .STATUS_OUT(status_out), .POINTER_OUT(pointer_out));
    bdmd_periph_model periph (.REF_CLK(ref_clk), .RSTN(rstn), .SFR_EN(sfr_en), .SFR_WR(sfr_wr),
        .SFR_ADDR(sfr_addr), .SFR_RDATA(sfr_rdata));
    // remember the address of each special register strobe
    always @(posedge ref_clk) begin
        if (sfr_en === 1'b1) begin
            last_addr <= sfr_addr;
            last_wr   <= sfr_wr;
            last_wd   <= sfr_wdata;
        end
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one core access; reads wait a bounded time for the answer
    task automatic acc(input logic wr, input logic [6:0] ofs, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        acc_en <= 1'b1; acc_wr <= wr; acc_ofs <= ofs; acc_wdata <= wd;
        @(posedge ref_clk);
        acc_en <= 1'b0;
        #1;
        if (!wr) begin
            while (acc_rvalid !== 1'b1 && n < 8) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            if (acc_rvalid !== 1'b1) begin
                n_fail++;
                $display("Error read answer expected 1 seen 0");
            end
            rd = acc_rdata;
        end
    endtask
    task automatic set_bank(input logic [1:0] b);
        acc(1'b1, 7'h03, {1'b0, b, 5'h00});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // bank select, mirrored status, special region and ram in each bank
    task automatic t_banks;
        logic [1:0] b;
        for (int i = 0; i < 4; i++) begin
            b = i[1:0];
            set_bank(b);
            check("bank bits", {7'h00, status_out[6:5]}, {7'h00, b});
            acc(1'b0, 7'h03, 8'h00);
            check("status mirror", {7'h00, rd[6:5]}, {7'h00, b});
            acc(1'b0, 7'h1F, 8'h00);
            check("special addr", last_addr, {b, 7'h1F});
            check("special data", {1'b0, rd}, {1'b0, {b[0], 7'h1F} ^ 8'hA5});
            acc(1'b1, 7'h20, 8'h30 + {6'h00, b});
        end
        for (int i = 0; i < 4; i++) begin
            b = i[1:0];
            set_bank(b);
            acc(1'b0, 7'h20, 8'h00);
            check("bank ram", {1'b0, rd}, {1'b0, 8'h30 + {6'h00, b}});
        end
    endtask
    // pointer access, mirrors and the offset zero port
    task automatic t_indirect;
        set_bank(2'b00);
        acc(1'b1, 7'h04, 8'h21);
        check("pointer", {1'b0, pointer_out}, 9'h021);
        acc(1'b1, 7'h00, 8'h77);
        acc(1'b0, 7'h21, 8'h00);
        check("indirect write", {1'b0, rd}, 9'h077);
        set_bank(2'b01);
        acc(1'b0, 7'h04, 8'h00);
        check("pointer mirror", {1'b0, rd}, 9'h021);
        acc(1'b1, 7'h04, 8'h83);
        acc(1'b0, 7'h00, 8'h00);
        check("indirect status", {7'h00, rd[6:5]}, 9'h001);
        acc(1'b1, 7'h04, 8'h00);
        acc(1'b0, 7'h00, 8'h00);
        check("self indirect", {1'b0, rd}, 9'h000);
        acc(1'b1, 7'h00, 8'h55);
        check("self write answer", {8'h00, acc_rvalid}, 9'h000);
        check("self write status", {7'h00, status_out[6:5]}, 9'h001);
        check("self write ptr", {1'b0, pointer_out}, 9'h000);
    endtask
    // special register write, indirect special read, shared ram window, clock enable
    task automatic t_special;
        set_bank(2'b10);
        acc(1'b1, 7'h15, 8'h5A);
        check("special write answer", {8'h00, acc_rvalid}, 9'h000);
        @(posedge ref_clk);
        #1;
        check("special write addr", last_addr, 9'h115);
        check("special write strobe", {8'h00, last_wr}, 9'h001);
        check("special write data", {1'b0, last_wd}, 9'h05A);
        acc(1'b1, 7'h04, 8'h0C);
        acc(1'b0, 7'h00, 8'h00);
        check("indirect special addr", last_addr, 9'h10C);
        check("indirect special data", {1'b0, rd}, 9'h0A9);
        set_bank(2'b11);
        acc(1'b1, 7'h75, 8'h9C);
        set_bank(2'b00);
        acc(1'b0, 7'h75, 8'h00);
        check("shared ram", {1'b0, rd}, 9'h09C);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        acc(1'b1, 7'h04, 8'hEE);
        repeat (2) @(posedge ref_clk);
        #1;
        check("frozen pointer", {1'b0, pointer_out}, 9'h00C);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        acc(1'b1, 7'h04, 8'hEE);
        check("thawed pointer", {1'b0, pointer_out}, 9'h0EE);
    endtask
    // reset in mid-run clears the bank field and the pointer
    task automatic t_reset;
        set_bank(2'b11);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("reset status", {1'b0, status_out}, 9'h000);
        check("reset pointer", {1'b0, pointer_out}, 9'h000);
        check("reset answer", {8'h00, acc_rvalid}, 9'h000);
        @(posedge ref_clk);
        rstn <= 1'b1;
        acc(1'b0, 7'h03, 8'h00);
        check("status after reset", {1'b0, rd}, 9'h000);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        final_report;
    end
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_banks;
        t_indirect;
        t_special;
        t_reset;
        final_report;
    end
endmodule
`default_nettype wire
